// ===== design/dcf_cmd_exec.sv
/*
  Command sequencer for self-diagnostic and write-cache flush commands,
  with error, status and interrupt registers on a plain register port.
  Assumes diagnostic engine, cache and media writer share clk_sys.
*/
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// [R1] Opcode 90h runs diagnostics, then clears busy
// [R2] Diagnostic code replaces error bits in register
// [R3] Opcode E7h writes all dirty cache entries
// [R4] Opcode EAh flushes exactly like E7h
// [R5] Flush reports good only after media commit
// [R6] Failed flush sets abort, error, clears busy
module dcf_cmd_exec
  import dcf_pkg::*;
(
  input  wire logic                      clk_sys,      // System clock
  input  wire logic                      rst_n,        // Sync reset
  input  wire logic [dcf_pkg::ADDR_W-1:0] regAddr,     // Register address
  input  wire logic [dcf_pkg::DATA_W-1:0] regWdata,    // Write data
  input  wire logic                      regWr,        // Write strobe
  input  wire logic                      regRd,        // Read strobe
  output logic      [dcf_pkg::DATA_W-1:0] regRdata,    // Read data
  output logic                           irq,          // Level interrupt
  output logic                           diagStart,    // Run diagnostics
  input  wire logic                      diagDone,     // Diagnostics over
  input  wire logic [dcf_pkg::DATA_W-1:0] diagCode,    // Diagnostic result
  input  wire logic                      cacheMark,    // Entry now dirty
  input  wire logic [dcf_pkg::CACHE_AW-1:0] cacheIdx,  // Entry marked
  output logic                           mediaReq,     // Write entry out
  output logic      [dcf_pkg::CACHE_AW-1:0] mediaIdx,  // Entry to write
  input  wire logic                      mediaAck,     // Media write over
  input  wire logic                      mediaErr      // Media write failed
);
  dcf_state_t          state_q;     // Sequencer state
  logic [7:0]          error_q;     // Error or diagnostic register
  logic [7:0]          status_q;    // Status register
  logic [CACHE_AW-1:0] scanIdx_q;   // Entry under scan
  logic [IRQ_W-1:0]    irqStat_q;   // Sticky events
  logic [IRQ_W-1:0]    irqEn_q;     // Event mask
  logic [IRQ_W-1:0]    irqSet;      // Events this cycle
  logic                rdDirty_q;   // Dirty bit of scanIdx_q
  logic                cmdWr;       // Command register write
  logic                cmdTake;     // Command accepted
  logic                entryClr;    // Entry committed to media
  logic                flushGood;   // Flush ended with all written
  logic                flushFail;   // Flush failed on media

  // Flush opcode decode, used for start and checks
  function automatic logic isFlush(input logic [7:0] op);
    isFlush = (op == OP_FLUSH) || (op == OP_FLUSH_EXT);
  endfunction

  // Command strobes; a command written while busy is ignored
  assign cmdWr     = regWr && regAddr == REG_COMMAND;
  assign cmdTake   = cmdWr && state_q == ST_IDLE;
  assign entryClr  = state_q == ST_WRITE && mediaAck && !mediaErr;
  assign flushFail = state_q == ST_WRITE && mediaAck && mediaErr;
  assign flushGood = state_q == ST_CHECK && !rdDirty_q
                     && scanIdx_q == CACHE_LAST;
  assign mediaReq  = state_q == ST_WRITE;
  assign mediaIdx  = scanIdx_q;
  assign diagStart = cmdTake && regWdata == OP_DIAG; // [R1]

  // Dirty-entry table of the write cache
  dcf_dirty_mem u_dirty (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .setEn     (cacheMark),
    .setIdx    (cacheIdx),
    .clrEn     (entryClr),
    .clrIdx    (scanIdx_q),
    .rdIdx     (scanIdx_q),
    .rdDirty_q (rdDirty_q)
  );

  // Sequencer state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmdTake && regWdata == OP_DIAG) begin
            state_q <= ST_DIAG; // [R1]
          end else if (cmdTake && isFlush(regWdata)) begin
            state_q <= ST_SCAN; // [R3] [R4]
          end
        end
        ST_DIAG: begin
          if (diagDone) begin
            state_q <= ST_IDLE; // [R1]
          end
        end
        // Read latency of the dirty table
        ST_SCAN: state_q <= ST_CHECK;
        ST_CHECK: begin
          if (rdDirty_q) begin
            state_q <= ST_WRITE; // [R3]
          end else if (scanIdx_q == CACHE_LAST) begin
            state_q <= ST_IDLE; // [R5]
          end else begin
            state_q <= ST_SCAN;
          end
        end
        ST_WRITE: begin
          if (flushFail) begin
            state_q <= ST_IDLE; // [R6]
          end else if (mediaAck) begin
            // Recheck the same entry; it may be dirty again
            state_q <= ST_SCAN; // [R5]
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Scan pointer over the cache entries
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scanIdx_q <= '0;
    end else if (cmdTake) begin
      scanIdx_q <= '0;
    end else if (state_q == ST_CHECK && !rdDirty_q
                 && scanIdx_q != CACHE_LAST) begin
      scanIdx_q <= scanIdx_q + 1'b1; // [R3]
    end
  end

  // Error register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      error_q <= ERROR_RST;
    end else if (cmdTake) begin
      // Unknown opcodes abort at once
      error_q <= (regWdata == OP_DIAG || isFlush(regWdata)) ?
                 8'h00 : (8'h01 << ER_ABORT);
    end else if (state_q == ST_DIAG && diagDone) begin
      error_q <= diagCode; // [R2]
    end else if (flushFail) begin
      error_q <= 8'h00 | (8'h01 << ER_ABORT); // [R6]
    end
  end

  // Status register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_q <= STATUS_RST;
    end else if (cmdTake) begin
      status_q[ST_BUSY] <= regWdata == OP_DIAG || isFlush(regWdata);
      status_q[ST_ERR]  <= !(regWdata == OP_DIAG || isFlush(regWdata));
      status_q[ST_FAULT] <= 1'b0;
    end else if (state_q == ST_DIAG && diagDone) begin
      status_q[ST_BUSY] <= 1'b0; // [R1]
      status_q[ST_ERR]  <= 1'b0;
    end else if (flushGood) begin
      status_q[ST_BUSY] <= 1'b0; // [R5]
      status_q[ST_ERR]  <= 1'b0;
    end else if (flushFail) begin
      status_q[ST_BUSY] <= 1'b0; // [R6]
      status_q[ST_ERR]  <= 1'b1;
    end
  end

  // Interrupt events: completion and abort
  always_comb begin
    irqSet = '0;
    irqSet[IRQ_DONE]  = (state_q == ST_DIAG && diagDone) || flushGood;
    irqSet[IRQ_ABORT] = flushFail ||
      (cmdTake && !(regWdata == OP_DIAG || isFlush(regWdata)));
  end

  // Sticky status; a new event wins over a clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= irqSet | (irqStat_q &
        ~((regWr && regAddr == REG_IRQ_CLEAR) ?
          regWdata[IRQ_W-1:0] : {IRQ_W{1'b0}}));
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqEn_q <= '0;
    end else if (regWr && regAddr == REG_IRQ_ENABLE) begin
      irqEn_q <= regWdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irqStat_q & irqEn_q);

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        REG_ERROR:      regRdata <= error_q;
        REG_STATUS:     regRdata <= status_q;
        REG_IRQ_STATUS: regRdata <= {{(DATA_W-IRQ_W){1'b0}}, irqStat_q};
        REG_IRQ_ENABLE: regRdata <= {{(DATA_W-IRQ_W){1'b0}}, irqEn_q};
        default:        regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // Diagnostic command starts the diagnostic state
  property p_diag_start;
    @(posedge clk_sys) disable iff (!rst_n)
      diagStart |=> state_q == ST_DIAG && status_q[ST_BUSY];
  endproperty
  a_diag_start: assert property (p_diag_start) // [R1]
    else $error("diag command did not start busy diagnostics");

  // Diagnostic result lands in the error register and clears busy
  property p_diag_code;
    @(posedge clk_sys) disable iff (!rst_n)
      state_q == ST_DIAG && diagDone |=>
        error_q == $past(diagCode) && !status_q[ST_BUSY];
  endproperty
  a_diag_code: assert property (p_diag_code) // [R2]
    else $error("diag code not reported or busy stuck");

  // Normal flush starts a scan from entry zero
  property p_flush_start;
    @(posedge clk_sys) disable iff (!rst_n)
      cmdTake && regWdata == OP_FLUSH |=>
        state_q == ST_SCAN && scanIdx_q == '0 && status_q[ST_BUSY];
  endproperty
  a_flush_start: assert property (p_flush_start) // [R3]
    else $error("flush command did not start a scan");

  // Extended flush behaves the same
  property p_flush_ext;
    @(posedge clk_sys) disable iff (!rst_n)
      cmdTake && regWdata == OP_FLUSH_EXT |=>
        state_q == ST_SCAN && scanIdx_q == '0 ##2 state_q != ST_IDLE;
  endproperty
  a_flush_ext: assert property (p_flush_ext) // [R4]
    else $error("extended flush did not scan");

  // Good completion only after the last entry was seen clean
  property p_flush_good;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(status_q[ST_BUSY]) && !status_q[ST_ERR] &&
      $past(state_q) == ST_CHECK |->
        $past(scanIdx_q) == CACHE_LAST && !$past(rdDirty_q);
  endproperty
  a_flush_good: assert property (p_flush_good) // [R5]
    else $error("flush completed before cache was clean");

  // A pending media write keeps the device busy
  property p_write_busy;
    @(posedge clk_sys) disable iff (!rst_n)
      mediaReq && !mediaAck |=> status_q[ST_BUSY] && mediaReq;
  endproperty
  a_write_busy: assert property (p_write_busy) // [R5]
    else $error("busy dropped while media write pending");

  // Media failure aborts the flush
  property p_flush_fail;
    @(posedge clk_sys) disable iff (!rst_n)
      flushFail |=> error_q[ER_ABORT] && status_q[ST_ERR] &&
        !status_q[ST_BUSY] && state_q == ST_IDLE;
  endproperty
  a_flush_fail: assert property (p_flush_fail) // [R6]
    else $error("failed flush not reported as aborted");

  // Interrupt follows enabled sticky events
  property p_irq_event;
    @(posedge clk_sys) disable iff (!rst_n)
      (|(irqSet & irqEn_q)) && !(regWr && regAddr == REG_IRQ_ENABLE)
        |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event)
    else $error("enabled event did not raise interrupt");
endmodule
`default_nettype wire

// ===== design/dcf_pkg.sv
/*
  Constants shared by the diagnostic and cache-flush command block:
  register offsets, opcodes, bit positions, reset values, cache size.
  Assumes one 50 MHz system clock and an 8-bit register port.
*/
package dcf_pkg;
  // Register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [2:0] REG_COMMAND    = 3'h0; // Write: opcode
  localparam logic [2:0] REG_ERROR      = 3'h1; // Read: error or diag code
  localparam logic [2:0] REG_STATUS     = 3'h2; // Read: status flags
  localparam logic [2:0] REG_IRQ_STATUS = 3'h3; // Read: sticky events
  localparam logic [2:0] REG_IRQ_CLEAR  = 3'h4; // Write 1 to clear
  localparam logic [2:0] REG_IRQ_ENABLE = 3'h5; // Read/write mask
  // Opcodes
  localparam logic [7:0] OP_DIAG      = 8'h90;
  localparam logic [7:0] OP_FLUSH     = 8'he7;
  localparam logic [7:0] OP_FLUSH_EXT = 8'hea;
  // Status bit positions
  localparam int ST_BUSY  = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK  = 4;
  localparam int ST_ERR   = 0;
  // Error bit position
  localparam int ER_ABORT = 2;
  // Interrupt event positions
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_W     = 2;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h50; // Ready and seek complete
  localparam logic [7:0] ERROR_RST  = 8'h01; // No error diagnostic code
  // Write cache tracking
  localparam int CACHE_AW = 4;
  localparam int CACHE_N  = 16;
  localparam logic [CACHE_AW-1:0] CACHE_LAST = 4'hf;
  // Command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DIAG, ST_SCAN, ST_CHECK, ST_WRITE
  } dcf_state_t;
endpackage

// ===== design/dcf_dirty_mem.sv
/*
  Dirty-entry table of the write cache: one bit per cache entry.
  Assumes set and clear requests on the system clock; read is registered.
*/
`timescale 1ns/10ps
`default_nettype none
module dcf_dirty_mem
  import dcf_pkg::*;
(
  input  wire logic                clk_sys,   // System clock
  input  wire logic                rst_n,     // Sync reset, active low
  input  wire logic                setEn,     // Mark an entry dirty
  input  wire logic [CACHE_AW-1:0] setIdx,    // Entry to mark
  input  wire logic                clrEn,     // Mark an entry written
  input  wire logic [CACHE_AW-1:0] clrIdx,    // Entry to clear
  input  wire logic [CACHE_AW-1:0] rdIdx,     // Entry to read
  output logic                     rdDirty_q  // Registered read data
);
  logic [CACHE_N-1:0] dirty_q; // One bit per entry

  // Per-entry update; a new write wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < CACHE_N; gi++) begin : g_ent
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          dirty_q[gi] <= 1'b0;
        end else if (setEn && setIdx == CACHE_AW'(gi)) begin
          dirty_q[gi] <= 1'b1;
        end else if (clrEn && clrIdx == CACHE_AW'(gi)) begin
          dirty_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdDirty_q <= 1'b0;
    end else begin
      rdDirty_q <= dirty_q[rdIdx];
    end
  end
endmodule
`default_nettype wire

// ===== verification/dcf_far_model.sv
/*
  Far-side model: diagnostic engine and media writer for the command block.
  Assumes one clock shared with the block; delay, code and fault set by bench.
*/
`timescale 1ns/10ps
`default_nettype none
module dcf_far_model
  import dcf_pkg::*;
(
  input  wire logic                clk_sys,   // System clock
  input  wire logic                rst_n,     // Sync reset, active low
  input  wire logic                diagStart, // Diagnostic start pulse
  output logic                     diagDone,  // Diagnostic done pulse
  output logic [DATA_W-1:0]        diagCode,  // Result code
  input  wire logic [DATA_W-1:0]   codeSet,   // Code to report
  input  wire logic [7:0]          waitSet,   // Reply delay in cycles
  input  wire logic                failSet,   // Fail media writes
  input  wire logic                mediaReq,  // Media write request
  input  wire logic [CACHE_AW-1:0] mediaIdx,  // Entry to write
  output logic                     mediaAck,  // Media write over
  output logic                     mediaErr,  // Media write failed
  output logic [CACHE_N-1:0]       written    // Entries committed
);
  logic       dRun; // Diagnostic running
  logic [7:0] dCnt; // Diagnostic wait count
  logic [7:0] mCnt; // Media wait count
  // Diagnostic engine; code is noise outside the done pulse
  always_ff @(posedge clk_sys) begin
    diagDone <= 1'b0;
    diagCode <= ~diagCode;
    if (!rst_n) begin
      dRun     <= 1'b0;
      dCnt     <= 8'h00;
      diagCode <= 8'h00;
    end else if (diagStart) begin
      dRun <= 1'b1;
      dCnt <= 8'h00;
    end else if (dRun) begin
      if (dCnt >= waitSet) begin
        dRun     <= 1'b0;
        diagDone <= 1'b1;
        diagCode <= codeSet;
      end else begin
        dCnt <= dCnt + 8'h01;
      end
    end
  end
  // Media writer; one ack per request, error line is noise between acks
  always_ff @(posedge clk_sys) begin
    mediaAck <= 1'b0;
    mediaErr <= ~mediaErr;
    if (!rst_n) begin
      mCnt     <= 8'h00;
      mediaErr <= 1'b0;
      written  <= '0;
    end else if (mediaReq && !mediaAck) begin
      if (mCnt >= waitSet) begin
        mCnt     <= 8'h00;
        mediaAck <= 1'b1;
        mediaErr <= failSet;
        // Only a good write counts as committed
        if (!failSet) begin
          written[mediaIdx] <= 1'b1;
        end
      end else begin
        mCnt <= mCnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
/*
  Self-checking bench for the diagnostic and flush command block.
  Assumes the far-side model answers diagnostics and media writes.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dcf_pkg::*;
  logic                clk_sys, rst_n, regWr, regRd, irq;    // Core pins
  logic [ADDR_W-1:0]   regAddr;                              // Address
  logic [DATA_W-1:0]   regWdata, regRdata, diagCode, codeSet, d; // Bytes
  logic                diagStart, diagDone, cacheMark;       // Strobes
  logic                mediaReq, mediaAck, mediaErr, failSet; // Media
  logic [CACHE_AW-1:0] cacheIdx, mediaIdx;                   // Entries
  logic [7:0]          waitSet;                              // Model delay
  logic [CACHE_N-1:0]  written, expDone, mask;               // Entry masks
  int                  errors, checks_done;                  // Counters
  dcf_cmd_exec u_dcf_cmd_exec (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq), .diagStart(diagStart),
    .diagDone(diagDone), .diagCode(diagCode), .cacheMark(cacheMark),
    .cacheIdx(cacheIdx), .mediaReq(mediaReq), .mediaIdx(mediaIdx),
    .mediaAck(mediaAck), .mediaErr(mediaErr));
  dcf_far_model u_dcf_far_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .diagStart(diagStart), .diagDone(diagDone), .diagCode(diagCode),
    .codeSet(codeSet), .waitSet(waitSet), .failSet(failSet),
    .mediaReq(mediaReq), .mediaIdx(mediaIdx), .mediaAck(mediaAck),
    .mediaErr(mediaErr), .written(written));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected status after a command ends, good or aborted
  function automatic logic [7:0] exp_stat(input logic bad);
    exp_stat         = STATUS_RST;
    exp_stat[ST_ERR] = bad;
  endfunction
  // Expected error register after a flush or a refused opcode
  function automatic logic [7:0] exp_err(input logic bad);
    exp_err = bad ? (8'h01 << ER_ABORT) : 8'h00;
  endfunction
  // Counts, verdict, end of run
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One-cycle register write
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask
  // Mark the entries of a mask dirty, back to back
  task automatic mark(input logic [CACHE_N-1:0] m);
    for (int i = 0; i < CACHE_N; i++) begin
      if (m[i]) begin
        @(posedge clk_sys);
        cacheMark <= 1'b1;
        cacheIdx  <= i[CACHE_AW-1:0];
      end
    end
    @(posedge clk_sys);
    cacheMark <= 1'b0;
  endtask
  // Poll status until busy drops, bounded
  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      rd(REG_STATUS);
      if (d[ST_BUSY] === 1'b0) return;
    end
    errors++;
    close_out();
  endtask
  // Main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    expDone = '0;
    {rst_n, regWr, regRd, cacheMark, failSet} = 5'h00;
    {regAddr, regWdata, cacheIdx, codeSet, waitSet} = '0;
    void'($urandom(85));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_STATUS);
    check(16'(d), 16'(STATUS_RST));
    rd(REG_ERROR);
    check(16'(d), 16'(ERROR_RST));
    rd(3'h7);
    check(16'(d), 16'h0000);
    wr(REG_IRQ_ENABLE, 8'h03);
    // Diagnostic with random code and delay
    codeSet <= 8'($urandom);
    waitSet <= 8'(5 + $urandom_range(15));
    wr(REG_COMMAND, OP_DIAG);
    rd(REG_STATUS);
    check(16'(d[ST_BUSY]), 16'h0001);
    wait_idle();
    check(16'(d), 16'(STATUS_RST));
    rd(REG_ERROR);
    check(16'(d), 16'(codeSet));
    check(16'(irq), 16'h0001);
    wr(REG_IRQ_CLEAR, 8'h03);
    rd(REG_IRQ_STATUS);
    check(16'(d), 16'h0000);
    check(16'(irq), 16'h0000);
    // Flushes: all dirty, all clean, then random; both opcodes
    for (int k = 0; k < 4; k++) begin
      mask = 16'($urandom);
      if (k == 0) mask = 16'hffff;
      if (k == 1) mask = 16'h0000;
      waitSet <= 8'($urandom_range(6));
      expDone = expDone | mask;
      mark(mask);
      wr(REG_COMMAND, k[0] ? OP_FLUSH_EXT : OP_FLUSH);
      // A command written while busy must be ignored
      if (k == 0) wr(REG_COMMAND, OP_DIAG);
      wait_idle();
      check(written, expDone);
      check(16'(d), 16'(exp_stat(1'b0)));
      rd(REG_ERROR);
      check(16'(d), 16'(exp_err(1'b0)));
      rd(REG_IRQ_STATUS);
      check(16'(d), 16'h0001);
      wr(REG_IRQ_CLEAR, 8'h01);
    end
    // Media write fails mid-flush
    failSet <= 1'b1;
    mark(16'h0100);
    wr(REG_COMMAND, OP_FLUSH);
    wait_idle();
    check(16'(d), 16'(exp_stat(1'b1)));
    rd(REG_ERROR);
    check(16'(d), 16'(exp_err(1'b1)));
    rd(REG_IRQ_STATUS);
    check(16'(d), 16'h0002);
    check(16'(irq), 16'h0001);
    // Masking the abort event drops the interrupt
    wr(REG_IRQ_ENABLE, 8'h01);
    rd(REG_IRQ_ENABLE);
    check(16'(d), 16'h0001);
    check(16'(irq), 16'h0000);
    // Unknown opcode when idle aborts at once; abort event is masked
    wr(REG_IRQ_CLEAR, 8'h03);
    wr(REG_COMMAND, 8'h00);
    rd(REG_STATUS);
    check(16'(d), 16'(exp_stat(1'b1)));
    rd(REG_ERROR);
    check(16'(d), 16'(exp_err(1'b1)));
    rd(REG_IRQ_STATUS);
    check(16'(d), 16'h0002);
    check(16'(irq), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
